// ---- logic/pel_pkg.sv ----
// Purpose: Shared constants and types of the protection element logic.
// Assumes: One 125 MHz clock, register port with one-cycle read latency.
// Notes:   Offsets are byte addresses on an 8-bit register address.
package pel_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 8;
  localparam int TICK_NS = 1_000_000;
  // Delay settings count in 1 ms ticks; least time rounds up
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Setting sets
  localparam int NUM_GROUPS = 6;
  localparam int NUM_SETS = 7;
  localparam logic [2:0] CTL_SET = 3'h6;
  localparam int VAL_W = 16;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GROUP = 8'h04;
  localparam logic [7:0] OFS_PROG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_RATIO = 8'h18;
  localparam logic [7:0] OFS_ACCESS = 8'h1C;
  localparam logic [7:0] OFS_PASSWD = 8'h20;
  localparam logic [7:0] OFS_SET_BASE = 8'h40;
  localparam logic [7:0] OFS_SET_END = 8'hAF;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_EN = 0;
  localparam int CTRL_CLASS = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_DIG = 4;
  localparam int EV_PKP = 0;
  localparam int EV_DPO = 1;
  localparam int EV_OP = 2;
  localparam int EV_PW = 3;
  localparam int NUM_EV = 4;
  localparam int ACC_UP = 0;
  localparam int ACC_DN = 1;
  localparam logic [2:0] GROUP_RST = 3'h1;
  localparam logic [1:0] ACC_RST = 2'h0;
  localparam logic [1:0] ACC_LAST = 2'h3;
  localparam logic [31:0] PW_RST = 32'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PEL_ABOVE = 2'b00,
    PEL_BELOW = 2'b01,
    PEL_INSIDE = 2'b10
  } pel_mode_t;

  typedef enum logic [1:0] {
    PEL_PW_IDLE = 2'b00,
    PEL_PW_NEW = 2'b01,
    PEL_PW_VERIFY = 2'b10
  } pel_pw_t;

  typedef struct packed {
    logic [VAL_W-1:0] lo;
    logic [VAL_W-1:0] hi;
    logic [VAL_W-1:0] on_dly;
    logic [VAL_W-1:0] off_dly;
  } pel_set_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pel_req_t;
endpackage

// ---- logic/pel_top.sv ----
// Purpose: One protection element with comparator, timers, setting
//          groups, relay-wide programmed gate and a register port.
// Assumes: Inputs synchronous to mclk; measured values unsigned.
// Notes:   Mode 3 of the comparator never picks up.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module pel_top #(
  parameter int MEAS_W = 16,
  parameter int TICK_CYCLES = pel_pkg::TICK_CYC
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire pel_pkg::pel_req_t req,
  output logic [31:0] rdata,
  // Measurement and supervision
  input wire logic [MEAS_W-1:0] meas_a,
  input wire logic [MEAS_W-1:0] meas_b,
  input wire logic dig_in,
  input wire logic block_in,
  // Element outputs
  output logic pickup,
  output logic operate,
  output logic relay_out,
  output logic trouble_led,
  output logic in_service_led,
  output logic irq
);
  localparam int SW = MEAS_W + pel_pkg::VAL_W + 1;

  // ==========================================================
  // Parameter checks
  if (MEAS_W < 16 || MEAS_W > 24)
  begin : g_bad_w
    $error("MEAS_W must lie in 16..24");
  end
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
  begin : g_bad_t
    $error("TICK_CYCLES must lie in 1..65535");
  end

  // ==========================================================
  // Register decode
  logic [4:0] ctrl;
  logic [2:0] group;
  logic programmed;
  logic [pel_pkg::NUM_EV-1:0] irq_stat;
  logic [pel_pkg::NUM_EV-1:0] irq_mask;
  logic [15:0] ratio_a;
  logic [15:0] ratio_b;
  logic [1:0] access_lvl;
  logic [31:0] pw_code;
  logic [31:0] pw_cand;
  pel_pkg::pel_pw_t pw_state;
  pel_pkg::pel_set_t sets [pel_pkg::NUM_SETS];

  wire wr = req.wr;
  wire [31:0] wd = req.wdata;
  wire wr_ctrl = wr && req.addr == pel_pkg::OFS_CTRL;
  wire wr_group = wr && req.addr == pel_pkg::OFS_GROUP;
  wire wr_prog = wr && req.addr == pel_pkg::OFS_PROG;
  wire wr_mask = wr && req.addr == pel_pkg::OFS_IRQ_MASK;
  wire wr_ratio = wr && req.addr == pel_pkg::OFS_RATIO;
  wire wr_acc = wr && req.addr == pel_pkg::OFS_ACCESS;
  wire wr_pw = wr && req.addr == pel_pkg::OFS_PASSWD;
  wire rd_irq = req.rd && req.addr == pel_pkg::OFS_IRQ_STAT;
  wire in_set = req.addr >= pel_pkg::OFS_SET_BASE
    && req.addr <= pel_pkg::OFS_SET_END;
  wire [7:0] set_off = req.addr - pel_pkg::OFS_SET_BASE;
  wire [2:0] set_idx = set_off[6:4];
  wire [1:0] set_fld = set_off[3:2];
  wire wr_set = wr && in_set;
  // Group numbers outside 1..6 are ignored, not stored
  wire group_ok = wd[2:0] >= 3'h1 && wd[2:0] <= 3'h6;

  // ==========================================================
  // Active setting set
  wire fn_en = ctrl[pel_pkg::CTRL_EN];
  wire ctl_class = ctrl[pel_pkg::CTRL_CLASS];
  wire digital = ctrl[pel_pkg::CTRL_DIG];
  wire [2:0] act_idx = ctl_class ? pel_pkg::CTL_SET : group - 3'h1;
  wire pel_pkg::pel_set_t act = sets[act_idx];

  // ==========================================================
  // Measurement: summed currents scaled to the larger rating
  // The sum is compared against pickup times the larger rating, so
  // no divider is needed and the pu base is the larger rating.
  wire [15:0] r_max = ratio_a >= ratio_b ? ratio_a : ratio_b;
  wire [SW-1:0] sum_a = SW'(meas_a * ratio_a);
  wire [SW-1:0] sum_b = SW'(meas_b * ratio_b);
  wire [SW-1:0] meas_sum = sum_a + sum_b;
  wire [SW-1:0] thr_lo = SW'(act.lo * r_max);
  wire [SW-1:0] thr_hi = SW'(act.hi * r_max);

  // ==========================================================
  // Comparator
  logic ana_hit;
  always_comb
  begin
    unique case (pel_pkg::pel_mode_t'(ctrl[pel_pkg::CTRL_MODE +: 2]))
      pel_pkg::PEL_ABOVE: ana_hit = meas_sum > thr_lo;
      pel_pkg::PEL_BELOW: ana_hit = meas_sum < thr_lo;
      pel_pkg::PEL_INSIDE:
        ana_hit = meas_sum >= thr_lo && meas_sum <= thr_hi;
      default: ana_hit = 1'b0;
    endcase
  end
  wire in_range = digital ? dig_in : ana_hit;
  wire run = fn_en && !block_in;

  // ==========================================================
  // Millisecond tick and delay timers
  logic [15:0] tick_cnt;
  logic [15:0] on_cnt;
  logic [15:0] off_cnt;
  wire tick = tick_cnt == 16'(TICK_CYCLES - 1);
  wire [16:0] on_inc = {1'b0, on_cnt} + 17'h1;
  wire [16:0] off_inc = {1'b0, off_cnt} + 17'h1;
  wire on_done = act.on_dly == 16'h0
    || (tick && on_inc >= {1'b0, act.on_dly});
  wire off_done = act.off_dly == 16'h0
    || (tick && off_inc >= {1'b0, act.off_dly});
  wire next_pickup = run && in_range;
  wire next_operate = run
    && (in_range ? (operate || on_done) : (operate && !off_done));
  wire [15:0] next_on_cnt = (!next_pickup || operate) ? 16'h0
    : (tick ? on_inc[15:0] : on_cnt);
  wire [15:0] next_off_cnt = (!run || in_range || !operate) ? 16'h0
    : (tick ? off_inc[15:0] : off_cnt);

  always_ff @(posedge mclk)
  begin
    if (reset || tick)
      tick_cnt <= 16'h0;
    else
      tick_cnt <= tick_cnt + 16'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pickup <= 1'b0;
      operate <= 1'b0;
      on_cnt <= 16'h0;
      off_cnt <= 16'h0;
    end
    else
    begin
      pickup <= next_pickup;
      operate <= next_operate;
      on_cnt <= next_on_cnt;
      off_cnt <= next_off_cnt;
    end
  end

  // ==========================================================
  // Events and interrupt; set wins over the read clear
  wire [pel_pkg::NUM_EV-1:0] ev;
  wire pw_stored;
  assign ev[pel_pkg::EV_PKP] = next_pickup && !pickup;
  assign ev[pel_pkg::EV_DPO] = pickup && !next_pickup;
  assign ev[pel_pkg::EV_OP] = next_operate && !operate;
  assign ev[pel_pkg::EV_PW] = pw_stored;
  wire [pel_pkg::NUM_EV-1:0] next_irq_stat =
    (rd_irq ? '0 : irq_stat) | ev;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      irq_stat <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // Relay-wide programmed gate
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      relay_out <= 1'b0;
      trouble_led <= 1'b1;
      in_service_led <= 1'b0;
    end
    else
    begin
      relay_out <= next_operate && programmed;
      trouble_led <= !programmed;
      in_service_led <= programmed;
    end
  end

  // ==========================================================
  // Password change sequence
  // Codes are 32 bits, so ten digit entries above that range alias.
  wire pw_match = wd == pw_code;
  wire pw_same = wd == pw_cand;
  assign pw_stored = wr_pw && pw_state == pel_pkg::PEL_PW_VERIFY
    && pw_same;
  pel_pkg::pel_pw_t next_pw_state;
  always_comb
  begin
    next_pw_state = pw_state;
    if (wr_pw)
    begin
      unique case (pw_state)
        pel_pkg::PEL_PW_IDLE:
          if (pw_match)
            next_pw_state = pel_pkg::PEL_PW_NEW;
        pel_pkg::PEL_PW_NEW:
          next_pw_state = pel_pkg::PEL_PW_VERIFY;
        pel_pkg::PEL_PW_VERIFY:
          next_pw_state = pel_pkg::PEL_PW_IDLE;
        default: next_pw_state = pel_pkg::PEL_PW_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pw_state <= pel_pkg::PEL_PW_IDLE;
      pw_code <= pel_pkg::PW_RST;
      pw_cand <= pel_pkg::PW_RST;
    end
    else
    begin
      pw_state <= next_pw_state;
      if (wr_pw && pw_state == pel_pkg::PEL_PW_NEW)
        pw_cand <= wd;
      if (pw_stored)
        pw_code <= pw_cand;
    end
  end

  // ==========================================================
  // Access level enumeration, wrapping at both ends
  wire [1:0] next_access = wd[pel_pkg::ACC_UP] ? access_lvl + 2'h1
    : (wd[pel_pkg::ACC_DN] ? access_lvl - 2'h1 : access_lvl);

  // ==========================================================
  // Writable registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl <= 5'h00;
      group <= pel_pkg::GROUP_RST;
      programmed <= 1'b0;
      irq_mask <= '0;
      ratio_a <= 16'h0001;
      ratio_b <= 16'h0001;
      access_lvl <= pel_pkg::ACC_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= wd[4:0];
      if (wr_group && group_ok)
        group <= wd[2:0];
      if (wr_prog)
        programmed <= wd[0];
      if (wr_mask)
        irq_mask <= wd[pel_pkg::NUM_EV-1:0];
      if (wr_ratio)
      begin
        ratio_a <= wd[15:0];
        ratio_b <= wd[31:16];
      end
      if (wr_acc)
        access_lvl <= next_access;
    end
  end

  // One generate entry per setting set
  for (genvar g = 0; g < pel_pkg::NUM_SETS; g++)
  begin : g_set
    wire hit = wr_set && set_idx == 3'(g);
    always_ff @(posedge mclk)
    begin
      if (reset)
        sets[g] <= '0;
      else if (hit)
      begin
        unique case (set_fld)
          2'h0: sets[g].lo <= wd[15:0];
          2'h1: sets[g].hi <= wd[15:0];
          2'h2: sets[g].on_dly <= wd[15:0];
          2'h3: sets[g].off_dly <= wd[15:0];
        endcase
      end
    end
  end

  // ==========================================================
  // Read path; unmapped addresses read zero
  pel_pkg::pel_set_t rd_set;
  assign rd_set = sets[set_idx];
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    if (in_set && set_idx < 3'(pel_pkg::NUM_SETS))
      rd_mux = {16'h0, rd_set[63 - 16 * set_fld -: 16]};
    else
    begin
      unique case (req.addr)
        pel_pkg::OFS_CTRL: rd_mux = {27'h0, ctrl};
        pel_pkg::OFS_GROUP: rd_mux = {29'h0, group};
        pel_pkg::OFS_PROG: rd_mux = {31'h0, programmed};
        pel_pkg::OFS_STATUS:
          rd_mux = {27'h0, in_range, programmed, run, operate, pickup};
        pel_pkg::OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat};
        pel_pkg::OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask};
        pel_pkg::OFS_RATIO: rd_mux = {ratio_b, ratio_a};
        pel_pkg::OFS_ACCESS: rd_mux = {30'h0, access_lvl};
        pel_pkg::OFS_PASSWD: rd_mux = {30'h0, pw_state};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata <= 32'h0;
    else if (req.rd)
      rdata <= rd_mux;
    else
      rdata <= 32'h0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  run_clear_a: assert property (!run |=> !pickup && !operate)
    else $error("flags not cleared after run dropped");
  block_run_a: assert property (block_in |-> !run)
    else $error("block did not withhold run");
  pickup_set_a: assert property (run && in_range |=> pickup)
    else $error("pickup missing with input in range");
  zero_on_a: assert property (
    run && in_range && act.on_dly == 16'h0 |=> operate && pickup)
    else $error("zero on-delay did not operate at pickup");
  on_wait_a: assert property (
    run && in_range && !operate && act.on_dly != 16'h0 && !tick
    |=> !operate)
    else $error("operate before on-delay elapsed");
  off_hold_a: assert property (
    run && !in_range && operate && act.off_dly != 16'h0 && !tick
    |=> operate && !pickup)
    else $error("operate dropped before off-delay elapsed");
  zero_off_a: assert property (
    run && !in_range && act.off_dly == 16'h0 |=> !operate)
    else $error("zero off-delay left operate set");
  relay_gate_a: assert property (
    !programmed |=> !relay_out && trouble_led && !in_service_led)
    else $error("unprogrammed relay not blocked");
  dpo_event_a: assert property (
    pickup && !next_pickup |=> irq_stat[pel_pkg::EV_DPO])
    else $error("dropout event missing");
  pw_guard_a: assert property (
    wr_pw && pw_state == pel_pkg::PEL_PW_IDLE && !pw_match
    |=> pw_state == pel_pkg::PEL_PW_IDLE && $stable(pw_code))
    else $error("password sequence entered without old code");
  fn_off_a: assert property (
    !fn_en && !wr_ctrl |=> !pickup ##1 !pickup)
    else $error("disabled element picked up");
endmodule

// ---- tb/pel_meas_model.sv ----
// Purpose: Measurement side model feeding the protection element.
// Assumes: Values are commanded by the bench; one clock domain.
// Notes:   Slow mode adds two cycles of latency, as a busy DSP would.
`timescale 1ns/1ns
module pel_meas_model (
  // Clock
  input wire logic mclk,
  // Commanded values
  input wire logic [15:0] cmd_a,
  input wire logic [15:0] cmd_b,
  input wire logic cmd_dig,
  input wire logic slow,
  // Toward the element
  output logic [15:0] meas_a,
  output logic [15:0] meas_b,
  output logic dig_in
);
  // ==========================================================
  // Delivery pipeline
  logic [32:0] p0 = '0;
  logic [32:0] p1 = '0;
  logic [32:0] p2 = '0;
  wire logic [32:0] sel_word = slow ? p2 : p0;

  always_ff @(posedge mclk)
  begin
    p0 <= {cmd_dig, cmd_b, cmd_a};
    p1 <= p0;
    p2 <= p1;
  end

  // Analog magnitudes and one logic state travel side by side
  assign {dig_in, meas_b, meas_a} = sel_word;
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the protection element.
// Assumes: Tick shortened to 4 clocks; read data one cycle late.
// Notes:   Each scenario is one task that drives and judges.
`timescale 1ns/1ns
module tb;
  // ==========================================================
  // Signals
  logic mclk = 1'b0;
  logic reset = 1'b1;
  pel_pkg::pel_req_t req = '0;
  logic [31:0] rdata;
  logic [15:0] meas_a;
  logic [15:0] meas_b;
  logic dig_in;
  logic block_in = 1'b0;
  logic pickup, operate, relay_out, trouble_led, in_service_led, irq;
  logic [15:0] cmd_a = 16'h0000;
  logic [15:0] cmd_b = 16'h0000;
  logic cmd_dig = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rv;
  int failures = 0;
  int check_count = 0;

  always #4 mclk = ~mclk;

  pel_top #(.MEAS_W(16), .TICK_CYCLES(4)) dut (.mclk(mclk),
    .reset(reset), .req(req), .rdata(rdata), .meas_a(meas_a),
    .meas_b(meas_b), .dig_in(dig_in), .block_in(block_in),
    .pickup(pickup), .operate(operate), .relay_out(relay_out),
    .trouble_led(trouble_led), .in_service_led(in_service_led),
    .irq(irq));
  pel_meas_model meas (.mclk(mclk), .cmd_a(cmd_a), .cmd_b(cmd_b),
    .cmd_dig(cmd_dig), .slow(slow), .meas_a(meas_a),
    .meas_b(meas_b), .dig_in(dig_in));

  // ==========================================================
  // Shared tasks
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask

  task automatic feed(input logic [15:0] a, input logic [15:0] b,
                      input logic d);
    @(posedge mclk);
    cmd_a <= a;
    cmd_b <= b;
    cmd_dig <= d;
  endtask

  // Output 0 pickup, 1 operate, 2 relay, 3 irq; stay holds v for n
  task automatic watch(input int w, input logic v, input int n,
                       input logic stay);
    int i;
    logic s;
    for (i = 0; i < n; i++)
    begin
      @(posedge mclk);
      #1;
      s = w == 0 ? pickup : w == 1 ? operate : w == 2 ? relay_out : irq;
      if ((s === v) != stay)
        break;
    end
    chk(32'(s), 32'(v));
  endtask

  task automatic set_prm(input int s, input logic [15:0] lo,
    input logic [15:0] hi, input logic [15:0] on, input logic [15:0] off);
    logic [7:0] b;
    b = pel_pkg::OFS_SET_BASE + 8'(s * 16);
    wr(b, {16'h0000, lo});
    wr(b + 8'h04, {16'h0000, hi});
    wr(b + 8'h08, {16'h0000, on});
    wr(b + 8'h0C, {16'h0000, off});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_basic;
    rdc(pel_pkg::OFS_CTRL, 32'h0);
    rdc(pel_pkg::OFS_GROUP, 32'h1);
    rdc(8'hF0, 32'h0);
    chk(32'(trouble_led), 32'h1);
    chk(32'(in_service_led), 32'h0);
    set_prm(0, 16'h0064, 16'h0064, 16'h0000, 16'h0000);
    feed(16'h00C8, 16'h0000, 1'b0);
    watch(0, 1'b0, 8, 1'b1);
    wr(pel_pkg::OFS_CTRL, 32'h1);
    watch(0, 1'b1, 4, 1'b0);
    chk(32'(operate), 32'h1);
    chk(32'(relay_out), 32'h0);
    wr(pel_pkg::OFS_PROG, 32'h1);
    watch(2, 1'b1, 3, 1'b0);
    chk(32'(in_service_led), 32'h1);
    chk(32'(trouble_led), 32'h0);
    rdc(pel_pkg::OFS_IRQ_STAT, 32'h5);
    feed(16'h0032, 16'h0000, 1'b0);
    watch(0, 1'b0, 6, 1'b0);
    chk(32'(operate), 32'h0);
    rdc(pel_pkg::OFS_IRQ_STAT, 32'h2);
    chk(32'(irq), 32'h0);
    wr(pel_pkg::OFS_IRQ_MASK, 32'hF);
    feed(16'h00C8, 16'h0000, 1'b0);
    watch(3, 1'b1, 6, 1'b0);
    rdc(pel_pkg::OFS_IRQ_STAT, 32'h5);
    watch(3, 1'b0, 3, 1'b0);
    wr(pel_pkg::OFS_IRQ_MASK, 32'h0);
  endtask

  task automatic t_modes;
    logic [15:0] vin [0:2];
    logic [15:0] vout [0:2];
    int m;
    vin = '{16'h0190, 16'h0032, 16'h00C8};
    vout = '{16'h0032, 16'h0190, 16'h0190};
    set_prm(0, 16'h0064, 16'h012C, 16'h0000, 16'h0000);
    for (m = 0; m < 3; m++)
    begin
      feed(vout[m], 16'h0000, 1'b0);
      wr(pel_pkg::OFS_CTRL, 32'(1 + 4 * m));
      watch(0, 1'b0, 6, 1'b0);
      feed(vin[m], 16'h0000, 1'b0);
      watch(0, 1'b1, 6, 1'b0);
    end
    feed(16'h0190, 16'h0000, 1'b0);
    wr(pel_pkg::OFS_CTRL, 32'hD);
    feed(16'h00C8, 16'h0000, 1'b0);
    watch(0, 1'b0, 8, 1'b1);
  endtask

  // Slow partner here, so latency is not mistaken for delay
  task automatic t_delays;
    @(posedge mclk);
    slow <= 1'b1;
    set_prm(0, 16'h0064, 16'h012C, 16'h0003, 16'h0003);
    wr(pel_pkg::OFS_CTRL, 32'h9);
    feed(16'h00C8, 16'h0000, 1'b0);
    watch(0, 1'b1, 8, 1'b0);
    watch(1, 1'b0, 4, 1'b1);
    watch(1, 1'b1, 20, 1'b0);
    feed(16'h0190, 16'h0000, 1'b0);
    watch(0, 1'b0, 8, 1'b0);
    watch(1, 1'b1, 4, 1'b1);
    watch(1, 1'b0, 20, 1'b0);
    feed(16'h00C8, 16'h0000, 1'b0);
    watch(1, 1'b1, 30, 1'b0);
    @(posedge mclk);
    block_in <= 1'b1;
    watch(1, 1'b0, 2, 1'b0);
    chk(32'(pickup), 32'h0);
    watch(0, 1'b0, 8, 1'b1);
    @(posedge mclk);
    block_in <= 1'b0;
    watch(0, 1'b1, 4, 1'b0);
    @(posedge mclk);
    slow <= 1'b0;
  endtask

  task automatic t_groups;
    int g;
    for (g = 1; g <= 6; g++)
    begin
      set_prm(g - 1, 16'(g * 100 - 50), 16'(g * 100 + 50), 16'h0000,
              16'h0000);
      wr(pel_pkg::OFS_GROUP, 32'(g));
      feed(16'(g * 100), 16'h0000, 1'b0);
      watch(0, 1'b1, 6, 1'b0);
    end
    wr(pel_pkg::OFS_GROUP, 32'h1);
    watch(0, 1'b0, 4, 1'b0);
    wr(pel_pkg::OFS_GROUP, 32'h7);
    rdc(pel_pkg::OFS_GROUP, 32'h1);
    set_prm(6, 16'h0226, 16'h028A, 16'h0000, 16'h0000);
    wr(pel_pkg::OFS_CTRL, 32'hB);
    watch(0, 1'b1, 4, 1'b0);
    wr(pel_pkg::OFS_GROUP, 32'h3);
    watch(0, 1'b1, 8, 1'b1);
    wr(pel_pkg::OFS_GROUP, 32'h1);
  endtask

  task automatic t_dig_ratio;
    wr(pel_pkg::OFS_CTRL, 32'h11);
    feed(16'h0064, 16'h0000, 1'b0);
    watch(0, 1'b0, 8, 1'b1);
    feed(16'h0000, 16'h0000, 1'b1);
    watch(0, 1'b1, 6, 1'b0);
    wr(pel_pkg::OFS_CTRL, 32'h9);
    wr(pel_pkg::OFS_RATIO, 32'h0003_0001);
    feed(16'h0064, 16'h0000, 1'b0);
    watch(0, 1'b0, 8, 1'b0);
    feed(16'h0000, 16'h0064, 1'b0);
    watch(0, 1'b1, 8, 1'b0);
    wr(pel_pkg::OFS_RATIO, 32'h0001_0001);
    wr(pel_pkg::OFS_CTRL, 32'h0);
  endtask

  task automatic t_access_pw;
    logic [31:0] cmd [0:5];
    logic [31:0] exp [0:5];
    int i;
    cmd = '{32'h1, 32'h1, 32'h2, 32'h2, 32'h2, 32'h3};
    exp = '{32'h1, 32'h2, 32'h1, 32'h0, 32'h3, 32'h0};
    rdc(pel_pkg::OFS_ACCESS, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      wr(pel_pkg::OFS_ACCESS, cmd[i]);
      rdc(pel_pkg::OFS_ACCESS, exp[i]);
    end
    rd(pel_pkg::OFS_IRQ_STAT);
    wr(pel_pkg::OFS_PASSWD, 32'h5);
    rdc(pel_pkg::OFS_PASSWD, 32'h0);
    wr(pel_pkg::OFS_PASSWD, 32'h0);
    rdc(pel_pkg::OFS_PASSWD, 32'h1);
    wr(pel_pkg::OFS_PASSWD, 32'h04D2);
    rdc(pel_pkg::OFS_PASSWD, 32'h2);
    wr(pel_pkg::OFS_PASSWD, 32'h04D2);
    rdc(pel_pkg::OFS_PASSWD, 32'h0);
    rdc(pel_pkg::OFS_IRQ_STAT, 32'h8);
    wr(pel_pkg::OFS_PASSWD, 32'h0);
    rdc(pel_pkg::OFS_PASSWD, 32'h0);
    wr(pel_pkg::OFS_PASSWD, 32'h04D2);
    wr(pel_pkg::OFS_PASSWD, 32'h0063);
    wr(pel_pkg::OFS_PASSWD, 32'h0062);
    rdc(pel_pkg::OFS_PASSWD, 32'h0);
    rdc(pel_pkg::OFS_IRQ_STAT, 32'h0);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_basic();
    t_modes();
    t_delays();
    t_groups();
    t_dig_ratio();
    t_access_pw();
    give_verdict();
  end

  // Whole run needs a few hundred clocks; a hundred times that is a hang
  initial
  begin
    #400000;
    failures++;
    give_verdict();
  end
endmodule
